/* File: core/anrb_bank.sv */
// module: negotiation page register bank with wishbone access
`timescale 1ns/1ns
`default_nettype none
module anrb_bank (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // status from negotiation machines (same clock)
  input wire logic rf_sent_i,
  input wire logic receive_machine_idle_i,
  input wire logic link_up_i,
  input wire logic partner_negotiation_capable_i,
  input wire logic an_complete_i,
  input wire logic resolved_fec_i,
  input wire logic sequencer_negotiation_failure_i,
  input wire logic [5:0] resolved_link_ready_onehot_i,
  // partner page captured by receive machine
  input wire logic partner_page_valid_i,
  input wire logic [15:0] partner_page_low_i,
  // machine generated page fields
  input wire logic [15:0] auto_base_low_i,
  input wire logic [31:0] auto_base_high_i,
  input wire logic [4:0] echoed_nonce_i,
  input wire logic sm_ack_i,
  input wire logic prbs_bit_i,
  input wire logic [5:0] auto_tech_i,
  input wire logic [1:0] auto_fec_i,
  input wire logic [2:0] auto_pause_i,
  // pages to transmit machine
  output logic [49:0] tx_base_page_o,
  output logic [49:0] tx_next_page_o,
  output logic [5:0] advertised_tech_ability_o,
  output logic [1:0] advertised_fec_ability_o,
  output logic [2:0] advertised_pause_ability_o
);
  import anrb_pkg::*;

  anrb_bus_if bus ();

  anrb_wb_slave u_wb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .dat_i(dat_i),
    .sel_i(sel_i),
    .ack_o(ack_o),
    .bus(bus)
  );

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] ubp_lo;
    logic [31:0] ubp_hi;
    logic [15:0] unp_lo;
    logic [31:0] unp_hi;
    logic [15:0] lp_lo;
    logic rf_sticky;
    logic link_sticky;
    logic fec_done;
    logic [31:0] rdata;
  } anrb_bank_s;

  anrb_bank_s s_q, s_d;

  // byte-lane merge for a register write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  logic [31:0] status_w;
  logic stat_rd;
  logic ovr_en;
  logic rd_take;
  logic [31:0] unp_lo_m;

  // live view of the status word
  always_comb begin
    status_w = '0;
    status_w[ST_RF_SENT] = s_q.rf_sticky;
    status_w[ST_RX_IDLE] = receive_machine_idle_i;
    status_w[ST_ABILITY] = 1'b1;
    status_w[ST_LINK] = s_q.link_sticky;
    status_w[ST_LP_CAP] = partner_negotiation_capable_i;
    status_w[ST_FEC] = s_q.fec_done;
    status_w[ST_SEQ_FAIL] = sequencer_negotiation_failure_i;
    status_w[ST_READY_LSB +: 6] = resolved_link_ready_onehot_i;
  end

  assign stat_rd = bus.rd && (bus.idx == IDX_STATUS);
  assign ovr_en = s_q.ctrl[CTRL_OVR_EN];
  // a read is taken at the edge that raises ack, so its data stands with ack
  assign rd_take = cyc_i && stb_i && !we_i && !ack_o;
  // upper half of the short next page word is dropped on purpose
  assign unp_lo_m = merge({16'h0000, s_q.unp_lo}, bus.wdat, bus.sel);

  // register updates, sticky flags and read mux
  always_comb begin
    s_d = s_q;
    // sticky flags: set beats the clear of a status read
    if (stat_rd) begin
      s_d.rf_sticky = 1'b0;
      s_d.link_sticky = 1'b0;
    end
    if (rf_sent_i) begin
      s_d.rf_sticky = 1'b1;
    end
    if (link_up_i) begin
      s_d.link_sticky = 1'b1;
    end
    // fec only counts once negotiation has completed
    s_d.fec_done = an_complete_i && resolved_fec_i;
    if (partner_page_valid_i) begin
      s_d.lp_lo = partner_page_low_i;
    end
    if (bus.wr) begin
      case (bus.idx)
        IDX_CTRL: s_d.ctrl = merge(s_q.ctrl, bus.wdat, bus.sel) & CTRL_WMASK;
        IDX_UBP_LO: s_d.ubp_lo = merge(s_q.ubp_lo, bus.wdat, bus.sel);
        IDX_UBP_HI: s_d.ubp_hi = merge(s_q.ubp_hi, bus.wdat, bus.sel);
        IDX_UNP_LO: s_d.unp_lo = unp_lo_m[15:0];
        IDX_UNP_HI: s_d.unp_hi = merge(s_q.unp_hi, bus.wdat, bus.sel);
        default: ;
      endcase
    end
    // read data registered with ack; status shows value before clearing
    case (bus.idx)
      IDX_CTRL: s_d.rdata = s_q.ctrl;
      IDX_STATUS: begin
        // an event arriving at the capture edge is reported, not lost
        s_d.rdata = status_w;
        s_d.rdata[ST_RF_SENT] = s_d.rf_sticky;
        s_d.rdata[ST_LINK] = s_d.link_sticky;
      end
      IDX_UBP_LO: s_d.rdata = s_q.ubp_lo;
      IDX_UBP_HI: s_d.rdata = s_q.ubp_hi;
      IDX_UNP_LO: s_d.rdata = {16'h0000, s_q.unp_lo};
      IDX_UNP_HI: s_d.rdata = s_q.unp_hi;
      IDX_LPBP_LO: s_d.rdata = {16'h0000, s_q.lp_lo};
      default: s_d.rdata = 32'h0000_0000;
    endcase
    if (!rd_take) begin
      s_d.rdata = s_q.rdata;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q.ctrl <= CTRL_RESET;
      s_q.ubp_lo <= UBP_LO_RESET;
      s_q.ubp_hi <= UBP_HI_RESET;
      s_q.unp_lo <= UNP_LO_RESET;
      s_q.unp_hi <= UNP_HI_RESET;
      s_q.lp_lo <= 16'h0000;
      s_q.rf_sticky <= 1'b0;
      s_q.link_sticky <= 1'b0;
      s_q.fec_done <= 1'b0;
      s_q.rdata <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  // read data stands from the ack cycle until the next read
  assign dat_o = s_q.rdata;

  // advertised abilities: overrides replace machine values when enabled
  always_comb begin
    if (ovr_en) begin
      advertised_tech_ability_o = s_q.ubp_lo[OVR_TECH_LSB +: 6];
      advertised_fec_ability_o = s_q.ubp_lo[OVR_FEC_LSB +: 2];
      advertised_pause_ability_o = s_q.ubp_lo[OVR_PAUSE_LSB +: 3];
    end else begin
      advertised_tech_ability_o = auto_tech_i;
      advertised_fec_ability_o = auto_fec_i;
      advertised_pause_ability_o = auto_pause_i;
    end
  end

  // base page assembly; nonce, ack and prbs never come from registers
  logic [15:0] bp_lo;
  logic [31:0] bp_hi;
  always_comb begin
    if (s_q.ctrl[CTRL_UBP_EN]) begin
      bp_lo = s_q.ubp_lo[15:0];
      bp_hi = s_q.ubp_hi;
    end else begin
      bp_lo = auto_base_low_i;
      bp_hi = auto_base_high_i;
    end
    // pause, tech and fec bits follow the override when it is active
    if (ovr_en) begin
      bp_lo[BP_PAUSE_LSB +: 2] = advertised_pause_ability_o[1:0];
      bp_hi[5 +: 6] = advertised_tech_ability_o;
      bp_hi[30 +: 2] = advertised_fec_ability_o;
    end
    bp_lo[9:5] = echoed_nonce_i;
    bp_lo[BP_ACK] = sm_ack_i;
    tx_base_page_o = {prbs_bit_i, 1'b0, bp_hi, bp_lo};
  end

  // next page assembly; null message when user pages are off
  logic [15:0] np_lo;
  always_comb begin
    if (s_q.ctrl[CTRL_UNP_EN]) begin
      np_lo = s_q.unp_lo;
      np_lo[BP_ACK] = sm_ack_i;
      tx_next_page_o = {prbs_bit_i, 1'b0, s_q.unp_hi, np_lo};
    end else begin
      np_lo = NULL_NP_LO;
      np_lo[BP_ACK] = sm_ack_i;
      tx_next_page_o = {prbs_bit_i, 1'b0, NULL_NP_HI, np_lo};
    end
  end
endmodule : anrb_bank
`default_nettype wire

/* File: core/anrb_bus_if.sv */
// interface: decoded register strobes between bus slave and bank
`timescale 1ns/1ns
`default_nettype none
interface anrb_bus_if;
  logic wr;
  logic rd;
  logic [7:0] idx;
  logic [31:0] wdat;
  logic [3:0] sel;
  modport slave (output wr, rd, idx, wdat, sel);
  modport bank (input wr, rd, idx, wdat, sel);
endinterface : anrb_bus_if
`default_nettype wire

/* File: core/anrb_pkg.sv */
// package: register map, field positions and reset values of the page bank
package anrb_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'hc0;
  localparam logic [7:0] IDX_STATUS = 8'hc2;
  localparam logic [7:0] IDX_UBP_LO = 8'hc3;
  localparam logic [7:0] IDX_UBP_HI = 8'hc4;
  localparam logic [7:0] IDX_UNP_LO = 8'hc5;
  localparam logic [7:0] IDX_UNP_HI = 8'hc6;
  localparam logic [7:0] IDX_LPBP_LO = 8'hc7;
  // control register fields
  localparam int CTRL_UBP_EN = 1;
  localparam int CTRL_UNP_EN = 2;
  localparam int CTRL_OVR_EN = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_0026;
  // status register fields
  localparam int ST_RF_SENT = 3;
  localparam int ST_RX_IDLE = 4;
  localparam int ST_ABILITY = 5;
  localparam int ST_LINK = 6;
  localparam int ST_LP_CAP = 7;
  localparam int ST_FEC = 8;
  localparam int ST_SEQ_FAIL = 9;
  localparam int ST_READY_LSB = 12;
  // user base page low word fields
  localparam int BP_PAUSE_LSB = 10;
  localparam int BP_RF = 13;
  localparam int BP_ACK = 14;
  localparam int BP_NP = 15;
  localparam int OVR_TECH_LSB = 16;
  localparam int OVR_FEC_LSB = 24;
  localparam int OVR_PAUSE_LSB = 28;
  // reset values of the page words and the null next page message
  localparam logic [31:0] UBP_LO_RESET = 32'h0000_0001;
  localparam logic [31:0] UBP_HI_RESET = 32'h0000_0000;
  localparam logic [15:0] UNP_LO_RESET = 16'h2001;
  localparam logic [31:0] UNP_HI_RESET = 32'h0000_0000;
  localparam logic [31:0] NULL_NP_HI = 32'h0000_0000;
  localparam logic [15:0] NULL_NP_LO = 16'h2001;
endpackage : anrb_pkg

/* File: core/anrb_wb_slave.sv */
// module: classic wishbone slave turning cycles into one-cycle strobes
`timescale 1ns/1ns
`default_nettype none
module anrb_wb_slave (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic ack_o,
  // strobes to bank
  anrb_bus_if.slave bus
);
  typedef struct packed {
    logic ack;
  } anrb_wb_s;
  anrb_wb_s s_q, s_d;
  // one wait state, then ack for a single cycle
  always_comb begin
    s_d = s_q;
    s_d.ack = cyc_i && stb_i && !s_q.ack;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  // strobes fire in the ack cycle: writes and read clears act on the ack edge
  assign ack_o = s_q.ack;
  assign bus.wr = s_q.ack && we_i;
  assign bus.rd = s_q.ack && !we_i;
  assign bus.idx = adr_i[9:2];
  assign bus.wdat = dat_i;
  assign bus.sel = sel_i;
endmodule : anrb_wb_slave
`default_nettype wire

/* File: test/anrb_an_model.sv */
// model: negotiation machines feeding status and page fields
`timescale 1ns/1ns
`default_nettype none
module anrb_an_model (
  // clock and freeze control
  input wire logic clk_i,
  input wire logic run_i,
  // packed machine outputs, sliced by the bench
  output logic [92:0] m_o
);
  integer seed = 32'hc22a5c95;
  logic [95:0] r;
  initial m_o = '0;
  // new values every cycle; frozen so combinational pages can be compared
  always @(posedge clk_i) begin
    r = {$random(seed), $random(seed), $random(seed)};
    if (run_i) m_o <= r[92:0];
  end
endmodule : anrb_an_model
`default_nettype wire

/* File: test/anrb_bank_bench.sv */
// bench: page bank against a register image model
`timescale 1ns/1ns
`default_nettype none
module anrb_bank_bench;
  import anrb_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, run = 1;
  logic rf = 0, lk = 0, lpv = 0, ack_o;
  logic [9:0] adr = '0;
  logic [3:0] sel = 4'hf, s;
  logic [31:0] dat = '0, r, d, dat_o, img [8], msk [8], ct [4];
  logic [49:0] tbp, tnp;
  logic [5:0] tech;
  logic [1:0] fec;
  logic [2:0] pau;
  logic [92:0] m;
  integer seed = 32'hc22a5c95, n_fail = 0, compares = 0;
  anrb_an_model anrb_an_model_inst (.clk_i(clk_i), .run_i(run), .m_o(m));
  anrb_bank anrb_bank_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(dat), .sel_i(sel),
    .dat_o(dat_o), .ack_o(ack_o), .rf_sent_i(rf),
    .receive_machine_idle_i(m[0]), .link_up_i(lk),
    .partner_negotiation_capable_i(m[1]), .an_complete_i(m[2]),
    .resolved_fec_i(m[3]), .sequencer_negotiation_failure_i(m[4]),
    .resolved_link_ready_onehot_i(m[10:5]), .partner_page_valid_i(lpv),
    .partner_page_low_i(m[26:11]), .auto_base_low_i(m[42:27]),
    .auto_base_high_i(m[92:61]), .echoed_nonce_i(m[47:43]),
    .sm_ack_i(m[48]), .prbs_bit_i(m[49]), .auto_tech_i(m[55:50]),
    .auto_fec_i(m[57:56]), .auto_pause_i(m[60:58]), .tx_base_page_o(tbp),
    .tx_next_page_o(tnp), .advertised_tech_ability_o(tech),
    .advertised_fec_ability_o(fec), .advertised_pause_ability_o(pau));
  initial forever #4 clk_i = ~clk_i;
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one classic cycle; read data is taken at the ack edge
  task automatic wb(input logic w, input logic [7:0] i,
                    input logic [31:0] wd, input logic [3:0] ws);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {1'b1, 1'b1, w, i, 2'b00, wd, ws};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) chk(64'h0, 64'h1);
    r = dat_o;
    {cyc, stb, we} <= 3'b000;
  endtask : wb
  task automatic pulse(input logic a, input logic b);
    @(posedge clk_i);
    {rf, lk, lpv} <= {a, b, 1'b1};
    @(posedge clk_i);
    {rf, lk, lpv} <= 3'b000;
  endtask : pulse
  // page words and advertised fields for one control setting
  task automatic pages(input logic [31:0] c);
    logic [15:0] bl, nl;
    logic [31:0] bh;
    wb(1'b1, IDX_CTRL, c, 4'hf);
    // outputs follow the new control word once the ack edge has passed
    @(posedge clk_i);
    bl = c[1] ? img[3][15:0] : m[42:27];
    bl = {bl[15], m[48], bl[13:10], m[47:43], bl[4:0]};
    bh = c[1] ? img[4] : m[92:61];
    if (c[5]) begin
      bl[11:10] = img[3][29:28];
      bh[10:5] = img[3][21:16];
      bh[31:30] = img[3][25:24];
    end
    nl = c[2] ? img[5][15:0] : NULL_NP_LO;
    nl = {nl[15], m[48], nl[13:0]};
    chk(tbp, {m[49], 1'b0, bh, bl});
    chk(tnp, {m[49], 1'b0, c[2] ? img[6] : NULL_NP_HI, nl});
    chk({tech, fec, pau}, c[5] ? {img[3][21:16], img[3][25:24], img[3][30:28]}
        : {m[55:50], m[57:56], m[60:58]});
  endtask : pages
  initial begin
    #100000;
    n_fail++;
    complete_run();
  end
  initial begin
    msk = '{CTRL_WMASK, 0, 0, '1, '1, 32'hffff, '1, 0};
    img = '{CTRL_RESET, 0, 0, UBP_LO_RESET, UBP_HI_RESET,
            {16'h0, UNP_LO_RESET}, UNP_HI_RESET, 0};
    ct = '{32'h0, 32'h6, 32'h26, 32'h22};
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset value, masked byte-lane write, read back; 0xc1 is unmapped
    for (int i = 0; i < 8; i++) if (i != 2) begin
      wb(1'b0, 8'hc0 + i[7:0], '0, 4'hf);
      chk(r, img[i]);
      d = $random(seed);
      s = 4'($random(seed));
      wb(1'b1, 8'hc0 + i[7:0], d, s);
      for (int b = 0; b < 4; b++) begin
        if (s[b]) img[i][b*8+:8] = d[b*8+:8] & msk[i][b*8+:8];
      end
      wb(1'b0, 8'hc0 + i[7:0], '0, 4'hf);
      chk(r, img[i]);
    end
    wb(1'b1, 8'h10, d, 4'hf);
    wb(1'b0, 8'h10, '0, 4'hf);
    chk(r, 64'h0);
    // sticky bits read set once, then clear; live bits from frozen model
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_i);
      run <= 1'b0;
      pulse(k[0], k[1]);
      wb(1'b0, IDX_STATUS, '0, 4'hf);
      chk(r & 32'h3fff8, {14'h0, m[10:5], 2'b0, m[4], m[2] & m[3], m[1],
          k[1], 1'b1, m[0], k[0], 3'b0});
      wb(1'b0, IDX_STATUS, '0, 4'hf);
      chk(r[6:3], {1'b0, 1'b1, m[0], 1'b0});
      wb(1'b0, IDX_LPBP_LO, '0, 4'hf);
      chk(r, m[26:11]);
      pages(ct[k]);
      run <= 1'b1;
    end
    // second reset mid-run restores the control word
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, IDX_CTRL, '0, 4'hf);
    chk(r, CTRL_RESET);
    complete_run();
  end
endmodule : anrb_bank_bench
`default_nettype wire

/* File: test/anrb_bank_chk.sv */
// checker: bus timing, status read-back and page bit relations
`timescale 1ns/1ns
`default_nettype none
module anrb_bank_chk (
  // watched ports
  input wire logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, prbs_bit_i,
  input wire logic [9:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic receive_machine_idle_i, partner_negotiation_capable_i,
  input wire logic an_complete_i, resolved_fec_i,
  input wire logic sequencer_negotiation_failure_i,
  input wire logic [5:0] resolved_link_ready_onehot_i,
  input wire logic [49:0] tx_base_page_o, tx_next_page_o
);
  import anrb_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // status read seen at the ack edge; its data stands in that same cycle
  wire logic st_rd = cyc_i && stb_i && !we_i && ack_o
    && adr_i == {IDX_STATUS, 2'b00};
  wire logic rd_take = cyc_i && stb_i && !we_i && !ack_o;
  wire logic fec_w = an_complete_i && resolved_fec_i;
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acked next cycle");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i) && $past(stb_i))
    else $error("ack without request");
  a_dat_hold: assert property (!$past(rst_i) && !$past(rd_take)
    |-> $stable(dat_o))
    else $error("read data moved outside a read");
  a_prbs_bit: assert property (tx_base_page_o[49] == prbs_bit_i
    && tx_next_page_o[49] == prbs_bit_i)
    else $error("page bit 49 not from machine");
  a_ability_one: assert property (st_rd |-> dat_o[5])
    else $error("ability bit not one");
  a_live_bits: assert property (st_rd |->
    dat_o[4] == $past(receive_machine_idle_i)
    && dat_o[7] == $past(partner_negotiation_capable_i)
    && dat_o[9] == $past(sequencer_negotiation_failure_i))
    else $error("live status bit wrong");
  a_ready_onehot: assert property (st_rd |->
    dat_o[17:12] == $past(resolved_link_ready_onehot_i))
    else $error("link ready field wrong");
  a_fec_done: assert property (st_rd |-> dat_o[8] == $past(fec_w, 2))
    else $error("fec status wrong");
  c_status_read: cover property (st_rd);
  c_write: cover property (ack_o && we_i);
  c_sticky_seen: cover property (st_rd && dat_o[3]);
endmodule : anrb_bank_chk
bind anrb_bank anrb_bank_chk anrb_bank_chk_inst (.clk_i, .rst_i, .cyc_i,
  .stb_i, .we_i, .ack_o, .prbs_bit_i, .adr_i, .dat_o, .receive_machine_idle_i,
  .partner_negotiation_capable_i, .an_complete_i, .resolved_fec_i,
  .sequencer_negotiation_failure_i, .resolved_link_ready_onehot_i,
  .tx_base_page_o, .tx_next_page_o);
`default_nettype wire
